// *** hdl/addr_gen_pkg.sv ***
package addr_gen_pkg;
  // Data space map
  localparam logic [15:0] REG_FILE_TOP = 16'h001f;
  localparam logic [15:0] INT_TOP = 16'h0fff;
  localparam int REG_FILE_SIZE = 32;
  localparam int REGIO_SIZE = 96;
  localparam int SRAM_SIZE = 4000;
  localparam int INT_SIZE = 4096;
  // Pointer register indices (low byte even)
  localparam logic [4:0] PTR_A_LO = 5'h1a;
  localparam logic [4:0] PTR_B_LO = 5'h1c;
  localparam logic [4:0] PTR_C_LO = 5'h1e;
  // Field positions
  localparam int EXT_MEM_ENABLE_BIT = 7;
  localparam int PROGRAM_PAGE_BIT = 0;
  // Timing in cycles
  localparam logic [2:0] INT_ACCESS_CYC = 3'h2;
  localparam logic [2:0] EXT_EXTRA_NOWAIT = 3'h1;
  localparam logic [2:0] EXT_EXTRA_WAIT = 3'h2;
  // Relative branch offset limits
  localparam int REL_MIN = -2048;
  localparam int REL_MAX = 2047;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef enum logic [2:0]
  {
    AM_DIRECT = 3'h0,
    AM_DISP = 3'h1,
    AM_IND = 3'h2,
    AM_PREDEC = 3'h3,
    AM_POSTINC = 3'h4,
    AM_IO = 3'h5
  } addr_mode_t;

  typedef enum logic [2:0]
  {
    PF_SEQ = 3'h0,
    PF_ABS = 3'h1,
    PF_IND = 3'h2,
    PF_REL = 3'h3
  } flow_t;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_INT = 4'b0010,
    ST_EXT = 4'b0100,
    ST_DONE = 4'b1000
  } acc_state_t;
endpackage

// *** hdl/data_decode.sv ***
`timescale 1ns/1ps
// Classifies a data address into register, I/O, SRAM, external or none (external disabled)
module data_decode
  import addr_gen_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic ext_enable,
  output logic hit_reg,
  output logic hit_io,
  output logic hit_sram,
  output logic hit_ext,
  output logic hit_none
);
  localparam logic [15:0] REGIO_LIM = 16'(REGIO_SIZE);
  localparam logic [15:0] REG_LIM = 16'(REG_FILE_SIZE);

  // Lowest 96 to registers/I/O, then SRAM up to the internal top
  always_comb
  begin
    hit_reg = addr < REG_LIM;
    hit_io = (addr >= REG_LIM) && (addr < REGIO_LIM);
    hit_sram = (addr >= REGIO_LIM) && (addr <= INT_TOP);
    hit_ext = (addr > INT_TOP) && ext_enable;
    hit_none = (addr > INT_TOP) && !ext_enable;
  end
endmodule // data_decode

// *** hdl/addr_gen.sv ***
`timescale 1ns/1ps
module addr_gen
  import addr_gen_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic acc_start,
  input wire addr_gen_pkg::addr_mode_t acc_mode,
  input wire logic [1:0] ptr_sel,
  input wire logic [5:0] field6,
  input wire logic [15:0] second_word,
  input wire logic acc_write,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] mcu_general_control,
  input wire logic [7:0] program_page_select,
  input wire logic wait_state_en,
  input wire logic stack_pc_xfer,
  input wire logic alu_we,
  input wire logic [4:0] alu_dst,
  input wire logic [7:0] alu_result,
  input wire logic [4:0] src_reg_field,
  input wire logic [4:0] alu_src2,
  input wire logic const_fetch_op,
  input wire logic ext_const_fetch_op,
  input wire addr_gen_pkg::flow_t flow_op,
  input wire logic [15:0] flow_imm,
  input wire logic [11:0] rel_offset,
  input wire logic pc_step,
  output logic [15:0] data_addr,
  output logic acc_busy,
  output logic acc_done,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic io_sel,
  output logic sram_sel,
  output logic [7:0] reg_rd_data,
  output logic [7:0] src_data,
  output logic [7:0] src2_data,
  output logic [15:0] pc,
  output logic [15:0] prog_word_addr,
  output logic prog_page,
  output logic prog_high_byte,
  output logic [7:0] ext_wdata
);
  // Register file plus pointer views
  logic [7:0] regs_q [32];
  logic [7:0] regs_d [32];
  logic [15:0] ptr_a, ptr_b, ptr_c, ptr_sel_val, ptr_new;
  logic ptr_wb;
  logic [15:0] op_addr, addr_d, addr_q;
  logic hit_reg, hit_io, hit_sram, hit_ext, hit_none;
  acc_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [7:0] wdat_q, wdat_d;
  logic [15:0] pc_q, pc_d;

  // All checks run on the system clock and rest while in reset
  default clocking ck_sys @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Pointer pairs, even register low
  assign ptr_a = {regs_q[PTR_A_LO + 5'h01], regs_q[PTR_A_LO]};
  assign ptr_b = {regs_q[PTR_B_LO + 5'h01], regs_q[PTR_B_LO]};
  assign ptr_c = {regs_q[PTR_C_LO + 5'h01], regs_q[PTR_C_LO]};

  // Operand address for each mode
  always_comb
  begin
    unique case (ptr_sel)
      2'h0: ptr_sel_val = ptr_a;
      2'h1: ptr_sel_val = ptr_b;
      default: ptr_sel_val = ptr_c;
    endcase
    ptr_new = ptr_sel_val;
    ptr_wb = 1'b0;
    unique case (acc_mode)
      AM_DIRECT: op_addr = second_word;
      AM_DISP: op_addr = (ptr_sel == 2'h1 ? ptr_b : ptr_c)
        + {10'h000, field6};
      AM_IND: op_addr = ptr_sel_val;
      AM_PREDEC:
      begin
        op_addr = ptr_sel_val - 16'h0001;
        ptr_new = op_addr;
        ptr_wb = 1'b1;
      end
      AM_POSTINC:
      begin
        op_addr = ptr_sel_val;
        ptr_new = ptr_sel_val + 16'h0001;
        ptr_wb = 1'b1;
      end
      AM_IO: op_addr = {10'h000, field6} + 16'(REG_FILE_SIZE);
      default: op_addr = ptr_sel_val;
    endcase
  end

  // Idle: decode the address being requested, else the latched one
  data_decode i_data_decode
  (
    .addr(st_q == ST_IDLE ? op_addr : addr_q),
    .ext_enable(mcu_general_control[EXT_MEM_ENABLE_BIT]),
    .hit_reg(hit_reg),
    .hit_io(hit_io),
    .hit_sram(hit_sram),
    .hit_ext(hit_ext),
    .hit_none(hit_none)
  );

  // Access sequencer: internal two cycles, external adds penalty
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wr_d = wr_q;
    wdat_d = wdat_q;
    unique case (st_q)
      ST_IDLE:
        if (acc_start)
        begin
          addr_d = op_addr; // Held for the whole access
          wr_d = acc_write;
          wdat_d = wr_data;
          if (hit_ext)
          begin
            st_d = ST_EXT;
            // Stack PC moves two bytes
            cnt_d = (wait_state_en ? EXT_EXTRA_WAIT : EXT_EXTRA_NOWAIT)
              + INT_ACCESS_CYC - 3'h1;
            if (stack_pc_xfer)
              cnt_d = 3'((wait_state_en ? EXT_EXTRA_WAIT : EXT_EXTRA_NOWAIT)
                * 2 + INT_ACCESS_CYC - 1);
          end
          else
          begin
            st_d = ST_INT;
            cnt_d = INT_ACCESS_CYC - 3'h1;
          end
        end
      ST_INT, ST_EXT:
      begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1)
          st_d = ST_DONE;
      end
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      addr_q <= 16'h0000;
      wr_q <= 1'b0;
      wdat_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      wdat_q <= wdat_d;
    end

  // Register file: ALU, pointer writeback, data-space store
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      regs_d[i] = regs_q[i];
    if (alu_we)
      regs_d[alu_dst] = alu_result;
    if (st_q == ST_IDLE && acc_start && ptr_wb)
    begin
      regs_d[{ptr_sel == 2'h0 ? 4'hd : ptr_sel == 2'h1 ? 4'he : 4'hf, 1'b0}]
        = ptr_new[7:0];
      regs_d[{ptr_sel == 2'h0 ? 4'hd : ptr_sel == 2'h1 ? 4'he : 4'hf, 1'b1}]
        = ptr_new[15:8];
    end
    if (st_q == ST_DONE && wr_q && hit_reg)
      regs_d[addr_q[4:0]] = wdat_q;
  end

  always_ff @(posedge clk)
    if (sys_rst)
      for (int i = 0; i < 32; i++)
        regs_q[i] <= REG_RESET;
    else
      for (int i = 0; i < 32; i++)
        regs_q[i] <= regs_d[i];

  // Program flow targets
  always_comb
  begin
    pc_d = pc_q;
    if (pc_step)
      unique case (flow_op)
        PF_SEQ: pc_d = pc_q + 16'h0001;
        PF_ABS: pc_d = flow_imm;
        PF_IND: pc_d = ptr_c;
        PF_REL: pc_d = pc_q + {{4{rel_offset[11]}}, rel_offset}
          + 16'h0001;
        default: pc_d = pc_q;
      endcase
  end

  always_ff @(posedge clk)
    if (sys_rst)
      pc_q <= PC_RESET;
    else
      pc_q <= pc_d;

  // Outputs; strobes only for external hits
  assign pc = pc_q;
  assign data_addr = addr_q;
  assign acc_busy = st_q != ST_IDLE;
  assign acc_done = st_q == ST_DONE;
  assign ext_rd_n = !(st_q == ST_EXT && !wr_q);
  assign ext_wr_n = !(st_q == ST_EXT && wr_q);
  assign io_sel = st_q == ST_INT && hit_io;
  assign sram_sel = st_q == ST_INT && hit_sram;
  // Store byte for the external bus, straight from the request latch
  assign ext_wdata = wdat_q;
  assign reg_rd_data = regs_q[addr_q[4:0]];
  assign src_data = regs_q[src_reg_field];
  assign src2_data = regs_q[alu_src2];
  // Constant fetch: word from bits 15..1, byte from bit 0
  // Word address parked at zero when no fetch runs, so memory stays quiet
  assign prog_word_addr = (const_fetch_op || ext_const_fetch_op)
    ? {1'b0, ptr_c[15:1]} : 16'h0000;
  assign prog_high_byte = ptr_c[0];
  assign prog_page = ext_const_fetch_op
    && program_page_select[PROGRAM_PAGE_BIT];

  // Checks; each access is followed from the edge that takes it
  sequence s_take;
    st_q == ST_IDLE && acc_start;
  endsequence
  // Internal answer: one busy cycle, then done
  sequence s_int_done;
    !acc_done ##1 acc_done;
  endsequence

  a_internal_strobes: assert property
    (st_q == ST_INT |-> ext_rd_n && ext_wr_n)
    else $error("strobe active on internal access");
  a_int_two_cyc: assert property
    (s_take ##0 !hit_ext |=> s_int_done)
    else $error("internal access not two cycles");
  // Judged at the request edge, since the enable may move mid-access
  a_ext_gate: assert property
    (s_take ##0 hit_none |=> st_q == ST_INT && ext_rd_n && ext_wr_n)
    else $error("external access while disabled");
  a_pc_abs: assert property
    (pc_step && flow_op == PF_ABS |=> pc == $past(flow_imm))
    else $error("absolute target wrong");
  a_pc_rel: assert property
    (pc_step && flow_op == PF_REL && !rel_offset[11]
      |=> pc == $past(pc) + 16'($past(rel_offset)) + 16'h0001)
    else $error("relative target wrong");
  a_post_inc: assert property
    (s_take ##0 (acc_mode == AM_POSTINC && ptr_sel[1] && !alu_we)
      |=> data_addr == $past(ptr_c) && ptr_c == $past(ptr_c) + 16'h0001)
    else $error("post-increment wrong");
  a_pre_dec: assert property
    (s_take ##0 (acc_mode == AM_PREDEC && ptr_sel == 2'h0 && !alu_we)
      |=> data_addr == ptr_a && ptr_a == $past(ptr_a) - 16'h0001)
    else $error("pre-decrement wrong");
  a_ext_nowait: assert property
    (s_take ##0 (hit_ext && !wait_state_en && !stack_pc_xfer)
      |=> ##2 acc_done)
    else $error("external penalty wrong");
  a_io_map: assert property
    (s_take ##0 (acc_mode == AM_IO)
      |=> data_addr == 16'($past(field6)) + 16'(REG_FILE_SIZE))
    else $error("I/O address wrong");
endmodule // addr_gen

// *** test/ext_sram_model.sv ***
`timescale 1ns/1ps
// External byte store; keeps only the last write for the bench to inspect
module ext_sram_model
(
  input wire logic clk,
  input wire logic ext_wr_n,
  input wire logic [15:0] data_addr,
  input wire logic [7:0] wr_data,
  output logic [15:0] last_addr,
  output logic [7:0] last_data
);
  // Capture while the write strobe is low; no read data path on this core
  always @(posedge clk)
  begin
    if (ext_wr_n === 1'b0)
    begin
      last_addr <= data_addr;
      last_data <= wr_data;
    end
  end
endmodule // ext_sram_model

// *** test/test_addr_gen.sv ***
`timescale 1ns/1ps
module test_addr_gen;
  import addr_gen_pkg::*;
  logic clk, sys_rst, acc_start, acc_write, wait_state_en, stack_pc_xfer;
  logic alu_we, const_fetch_op, ext_const_fetch_op, pc_step;
  addr_mode_t acc_mode;
  flow_t flow_op;
  logic [1:0] ptr_sel;
  logic [5:0] field6;
  logic [15:0] second_word, flow_imm, data_addr, pc, prog_word_addr;
  logic [15:0] got_addr, last_addr;
  logic [7:0] wr_data, mcu_general_control, program_page_select;
  logic [7:0] alu_result, reg_rd_data, src_data, src2_data, last_data;
  logic [4:0] alu_dst, src_reg_field, alu_src2;
  logic [11:0] rel_offset;
  logic acc_busy, acc_done, ext_rd_n, ext_wr_n, io_sel, sram_sel;
  logic prog_page, prog_high_byte, rd_seen, wr_seen;
  logic [7:0] ext_wdata;
  logic [2:0] sel_seen;
  int errors, n_compared, cyc;
  addr_gen i_addr_gen (.clk(clk), .sys_rst(sys_rst), .acc_start(acc_start),
    .acc_mode(acc_mode), .ptr_sel(ptr_sel), .field6(field6),
    .second_word(second_word), .acc_write(acc_write), .wr_data(wr_data),
    .mcu_general_control(mcu_general_control),
    .program_page_select(program_page_select),
    .wait_state_en(wait_state_en), .stack_pc_xfer(stack_pc_xfer),
    .alu_we(alu_we), .alu_dst(alu_dst), .alu_result(alu_result),
    .src_reg_field(src_reg_field), .alu_src2(alu_src2),
    .const_fetch_op(const_fetch_op), .ext_const_fetch_op(ext_const_fetch_op),
    .flow_op(flow_op), .flow_imm(flow_imm), .rel_offset(rel_offset),
    .pc_step(pc_step), .data_addr(data_addr), .acc_busy(acc_busy),
    .acc_done(acc_done), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .io_sel(io_sel), .sram_sel(sram_sel), .reg_rd_data(reg_rd_data),
    .src_data(src_data), .src2_data(src2_data), .pc(pc),
    .prog_word_addr(prog_word_addr), .prog_page(prog_page),
    .prog_high_byte(prog_high_byte), .ext_wdata(ext_wdata));
  ext_sram_model i_ext_sram_model (.clk(clk), .ext_wr_n(ext_wr_n),
    .data_addr(data_addr), .wr_data(ext_wdata), .last_addr(last_addr),
    .last_data(last_data));

  // 20 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One access; records cycles to done, address in c1 and any strobe
  task automatic acc(input addr_mode_t m, input logic [1:0] s,
    input logic [5:0] f, input logic [15:0] w, input logic wr);
    @(posedge clk);
    acc_mode <= m;
    ptr_sel <= s;
    field6 <= f;
    second_word <= w;
    acc_write <= wr;
    acc_start <= 1'b1;
    cyc = 0;
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    sel_seen = 3'h0;
    do
    begin
      @(posedge clk);
      acc_start <= 1'b0;
      cyc++;
      #1;
      if (cyc == 1)
      begin
        got_addr = data_addr;
        sel_seen = {acc_busy, io_sel, sram_sel};
      end
      if (ext_rd_n === 1'b0)
        rd_seen = 1'b1;
      if (ext_wr_n === 1'b0)
        wr_seen = 1'b1;
    end while (acc_done !== 1'b1 && cyc < 20);
  endtask

  task automatic wreg(input logic [4:0] r, input logic [7:0] v);
    @(posedge clk);
    alu_we <= 1'b1;
    alu_dst <= r;
    alu_result <= v;
    @(posedge clk);
    alu_we <= 1'b0;
    src_reg_field <= r;
    #1;
  endtask

  task automatic rreg(input logic [4:0] r);
    @(posedge clk);
    src_reg_field <= r;
    #1;
  endtask

  task automatic step(input flow_t f, input logic [15:0] imm,
    input logic [11:0] off);
    @(posedge clk);
    flow_op <= f;
    flow_imm <= imm;
    rel_offset <= off;
    pc_step <= 1'b1;
    @(posedge clk);
    pc_step <= 1'b0;
    #1;
  endtask

  task automatic t_ptr();
    logic [7:0] v [6] = '{8'h00, 8'h01, 8'hc0, 8'h0f, 8'hfe, 8'h12};
    for (int i = 0; i < 6; i++)
    begin
      wreg(5'(26 + i), v[i]);
      chk("reg write", {8'h00, src_data}, {8'h00, v[i]});
    end
    @(posedge clk);
    alu_src2 <= 5'h1f;
    #1;
    chk("read port 2", {8'h00, src2_data}, 16'h0012);
    for (int i = 0; i < 3; i++)
    begin
      acc(AM_IND, 2'(i), 6'h00, 16'h0000, 1'b0);
      chk("ind addr", got_addr, {v[2 * i + 1], v[2 * i]});
      chk("int cycles", 16'(cyc), 16'h0002);
      chk("strobes", {14'h0, rd_seen, wr_seen}, 16'h0000);
    end
    $display("test pointers done");
  endtask

  task automatic t_mode();
    acc(AM_PREDEC, 2'h0, 6'h00, 16'h0000, 1'b0);
    chk("predec addr", got_addr, 16'h00ff);
    rreg(5'h1a);
    chk("predec lo", {8'h00, src_data}, 16'h00ff);
    acc(AM_POSTINC, 2'h2, 6'h00, 16'h0000, 1'b0);
    chk("postinc addr", got_addr, 16'h12fe);
    rreg(5'h1e);
    chk("postinc lo", {8'h00, src_data}, 16'h00ff);
    acc(AM_DISP, 2'h1, 6'h3f, 16'h0000, 1'b0);
    chk("disp addr", got_addr, 16'h0fff);
    chk("sram select", {13'h0, sel_seen}, 16'h0005);
    acc(AM_IO, 2'h0, 6'h3f, 16'h0000, 1'b0);
    chk("io addr", got_addr, 16'h005f);
    chk("io select", {13'h0, sel_seen}, 16'h0006);
    @(posedge clk);
    wr_data <= 8'h3c;
    acc(AM_DIRECT, 2'h0, 6'h00, 16'h0005, 1'b1);
    chk("direct addr", got_addr, 16'h0005);
    chk("reg select", {13'h0, sel_seen}, 16'h0004);
    rreg(5'h05);
    chk("reg as data", {8'h00, src_data}, 16'h003c);
    chk("reg load", {8'h00, reg_rd_data}, 16'h003c);
    $display("test modes done");
  endtask

  task automatic t_ext();
    logic [15:0] a [4] = '{16'h1000, 16'hffff, 16'h0fff, 16'h2000};
    logic [15:0] e [4] = '{16'h0003, 16'h0004, 16'h0002, 16'h0002};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      mcu_general_control <= (i == 3) ? 8'h00 : 8'h80;
      wait_state_en <= (i == 1);
      wr_data <= 8'(8'h50 + i);
      acc(AM_DIRECT, 2'h0, 6'h00, a[i], 1'(i));
      chk("ext cycles", 16'(cyc), e[i]);
      chk("strobe seen", {15'h0, wr_seen}, {15'h0, i == 1});
    end
    chk("ext stored", last_addr, 16'hffff);
    chk("ext data", {8'h00, last_data}, 16'h0051);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      mcu_general_control <= 8'h80;
      wait_state_en <= 1'(i);
      stack_pc_xfer <= 1'b1;
      acc(AM_DIRECT, 2'h0, 6'h00, 16'h8000, 1'b0);
      chk("stack cycles", 16'(cyc), 16'(4 + 2 * i));
      chk("read strobe", {15'h0, rd_seen}, 16'h0001);
    end
    @(posedge clk);
    stack_pc_xfer <= 1'b0;
    $display("test external done");
  endtask

  task automatic t_flow();
    @(posedge clk);
    const_fetch_op <= 1'b1;
    ext_const_fetch_op <= 1'b1;
    program_page_select <= 8'h01;
    rreg(5'h1e);
    chk("word addr", prog_word_addr, 16'h097f);
    chk("byte page", {14'h0, prog_high_byte, prog_page}, 16'h0003);
    @(posedge clk);
    program_page_select <= 8'h00;
    rreg(5'h1e);
    chk("low page", {15'h0, prog_page}, 16'h0000);
    @(posedge clk);
    program_page_select <= 8'h01;
    ext_const_fetch_op <= 1'b0;
    rreg(5'h1e);
    chk("plain fetch page", {15'h0, prog_page}, 16'h0000);
    chk("plain word addr", prog_word_addr, 16'h097f);
    step(PF_ABS, 16'hfffe, 12'h000);
    chk("abs pc", pc, 16'hfffe);
    step(PF_IND, 16'h0000, 12'h000);
    chk("ind pc", pc, 16'h12ff);
    step(PF_REL, 16'h0000, 12'h800);
    chk("rel back", pc, 16'h0b00);
    step(PF_REL, 16'h0000, 12'h7ff);
    chk("rel fwd", pc, 16'h1300);
    step(PF_SEQ, 16'h0000, 12'h000);
    chk("seq pc", pc, 16'h1301);
    $display("test flow done");
  endtask

  // Stimulus: all inputs set at time zero, reset for 20 cycles
  initial
  begin
    {sys_rst, acc_start, acc_write, wait_state_en, stack_pc_xfer} = 5'b10000;
    {alu_we, const_fetch_op, ext_const_fetch_op, pc_step} = 4'h0;
    acc_mode = AM_DIRECT;
    flow_op = PF_SEQ;
    {ptr_sel, field6, second_word, flow_imm, rel_offset} = '0;
    {wr_data, mcu_general_control, program_page_select} = '0;
    {alu_result, alu_dst, src_reg_field, alu_src2} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset idle", {13'h0, acc_busy, ext_rd_n, ext_wr_n}, 16'h0003);
    chk("reset pc", pc, 16'h0000);
    t_ptr();
    t_mode();
    t_ext();
    t_flow();
    final_report();
  end

  // Whole run needs about 110 cycles; generous margin
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule // test_addr_gen
